// ===== logic/curtain_pkg.sv
// constants, register layouts and types of the restart interlock and contactor check
package curtain_pkg;

  // clock and documented times
  localparam int CLK_KHZ       = 100_000;   // 100 MHz reference clock
  localparam int PRESS_MIN_MS  = 150;       // shortest valid reset press
  localparam int PRESS_MAX_MS  = 4000;      // longest valid reset press
  localparam int FB_TIMEOUT_MS = 350;       // feedback must follow the outputs within this
  localparam int DEBOUNCE_MS   = 1;         // stable time of the reset button
  localparam int PRESS_MIN_CYC = PRESS_MIN_MS * CLK_KHZ;
  localparam int PRESS_MAX_CYC = PRESS_MAX_MS * CLK_KHZ;
  localparam int FB_LIMIT_CYC  = FB_TIMEOUT_MS * CLK_KHZ;
  localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_KHZ;

  // widths
  localparam int CNT_W     = 29;
  localparam int IDX_W     = 10;
  localparam int MAX_UNITS = 3;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [IDX_W-1:0] idx_t;
  typedef logic [2:0]       unit_t;
  localparam unit_t UNITS_LIMIT = 3'h3;     // largest cascade allowed

  // register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_BEAMS    = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // register layouts
  typedef struct packed {
    logic [27:0] rsvd;
    unit_t       units;
    logic        scan_en;
  } ctrl_t;
  typedef struct packed {
    logic [7:0]      rsvd;
    logic [2:0][7:0] cnt;
  } beams_t;
  typedef struct packed {
    logic lockout;
    logic out_off;
    logic out_on;
    logic field_int;
  } irq_t;

  typedef enum logic [2:0] {
    FLT_NONE, FLT_INTERNAL, FLT_OPTICAL, FLT_CONTACTOR,
    FLT_CASCADE, FLT_RESTART, FLT_OUTPUT, FLT_SUPPLY
  } fault_t;

  typedef struct packed {
    logic [21:0] rsvd;
    fault_t      fault;
    logic        lockout;
    logic        outputs_on;
    logic        field_clear;
    logic        restart_cfg;
    logic        monitor_cfg;
    logic        fb_closed;
    logic        fb_pending;
  } status_t;

  localparam logic [31:0] CTRL_RST     = 32'h0000_0002;  // one unit, scanning off
  localparam logic [31:0] BEAMS_RST    = 32'h0010_1010;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_LOCKOUT} state_t;

endpackage

// ===== logic/restart_interlock_and_contactor_check.sv
// receiver control: restart interlock, contactor feedback check, scan and cascade supervision
//
// How it works
// - field interruption latches outputs off until reset with interlock; automatic restart switches back on
// - supply return keeps outputs off until reset with interlock; automatic restart switches on
// - valid press lasts 0.15 s to 4 s
// - valid reset with clear field turns outputs on
// - wiring input selects interlock; else automatic restart
// - wiring input enables contactor feedback monitoring
// - scan steps from first to last beam
// - coded sync beam is beam nearest connector
// - more than three cascaded units is a fault
// - master alone drives outputs and indicators
// - cascaded units may differ in beam count
// - lockout shows which of seven faults occurred
// - feedback must be closed before switching on
// - feedback must follow outputs within 350 ms
// - contactor fault lockout cleared only by power cycle
`timescale 1ns/1ps
`default_nettype none
module restart_interlock_and_contactor_check #(
  parameter int PRESS_MIN_CYC = curtain_pkg::PRESS_MIN_CYC,
  parameter int PRESS_MAX_CYC = curtain_pkg::PRESS_MAX_CYC,
  parameter int FB_LIMIT_CYC  = curtain_pkg::FB_LIMIT_CYC,
  parameter int DEBOUNCE_CYC  = curtain_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // wiring configuration
  input  wire logic                 restart_cfg,
  input  wire logic                 monitor_cfg,
  input  wire logic                 master_cfg,
  // operator and contactors
  input  wire logic                 reset_btn,
  input  wire logic                 fb_closed,
  // optics and cascade
  input  wire logic                 beam_lit,
  input  wire logic                 sync_code_ok,
  input  wire logic                 cascade_link_ok,
  // supervision inputs
  input  wire logic                 internal_fault,
  input  wire logic                 supply_fault,
  input  wire logic [1:0]           output_readback,
  // machine side
  output logic [1:0]                safety_switching_output,
  output logic                      lockout,
  output curtain_pkg::fault_t       fault_code,
  output logic                      irq
);

  localparam curtain_pkg::cnt_t MIN_C  = curtain_pkg::cnt_t'(PRESS_MIN_CYC);
  localparam curtain_pkg::cnt_t MAX_C  = curtain_pkg::cnt_t'(PRESS_MAX_CYC);
  localparam curtain_pkg::cnt_t SAT_C  = curtain_pkg::cnt_t'(PRESS_MAX_CYC + 1);
  localparam curtain_pkg::cnt_t FB_C   = curtain_pkg::cnt_t'(FB_LIMIT_CYC - 1);
  localparam curtain_pkg::cnt_t DEB_C  = curtain_pkg::cnt_t'(DEBOUNCE_CYC - 1);

  // sum of beams over the units in use; each unit keeps its own count
  function automatic curtain_pkg::idx_t beams_total(curtain_pkg::beams_t b, curtain_pkg::unit_t n);
    curtain_pkg::idx_t s;
    s = '0;
    for (int i = 0; i < curtain_pkg::MAX_UNITS; i++)
    begin
      if (curtain_pkg::unit_t'(i) < n)
        s = s + curtain_pkg::idx_t'(b.cnt[i]);
    end
    return s;
  endfunction

  curtain_pkg::ctrl_t  ctrl_r;
  curtain_pkg::beams_t beams_r;
  curtain_pkg::irq_t   irq_stat_r, irq_mask_r, ev;
  curtain_pkg::state_t state_r, state_nxt;
  curtain_pkg::fault_t fault_r, fault_now;
  curtain_pkg::status_t st;
  curtain_pkg::cnt_t   deb_cnt_r, press_cnt_r, fbt_r;
  curtain_pkg::idx_t   idx_r, total, last_idx;
  logic        btn_s1_r, btn_s2_r, btn_db_r, pwr_press_r, valid_reset_r;
  logic        acc_r, field_clear_r, field_prev_r, fb_pending_r, mismatch_r;
  logic [1:0]  outs_r;
  logic [31:0] prdata_r, rd_word;

  // apb decode: zero wait states, unmapped offsets answer with pslverr
  wire setup      = psel & ~penable;
  wire wr         = psel & penable & pwrite;
  wire hit_ctrl   = paddr == curtain_pkg::ADDR_CTRL;
  wire hit_beams  = paddr == curtain_pkg::ADDR_BEAMS;
  wire hit_status = paddr == curtain_pkg::ADDR_STATUS;
  wire hit_istat  = paddr == curtain_pkg::ADDR_IRQ_STAT;
  wire hit_imask  = paddr == curtain_pkg::ADDR_IRQ_MASK;
  wire unmapped   = ~(hit_ctrl | hit_beams | hit_status | hit_istat | hit_imask);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & unmapped;
  assign prdata   = prdata_r;
  assign rd_word  = hit_ctrl   ? ctrl_r :
                    hit_beams  ? beams_r :
                    hit_status ? st :
                    hit_istat  ? {28'h0000000, irq_stat_r} :
                    hit_imask  ? {28'h0000000, irq_mask_r} : 32'h0000_0000;

  // read data captured in the setup cycle so it stands through the access cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata_r <= 32'h0000_0000;
    else if (setup)
      prdata_r <= rd_word;
  end

  // software registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r     <= curtain_pkg::CTRL_RST;
      beams_r    <= curtain_pkg::BEAMS_RST;
      irq_mask_r <= curtain_pkg::IRQ_MASK_RST;
    end
    else if (wr)
    begin
      if (hit_ctrl)  ctrl_r     <= pwdata;
      if (hit_beams) beams_r    <= pwdata;
      if (hit_imask) irq_mask_r <= pwdata[3:0];
    end
  end

  // reset button: two-stage synchroniser then stable-time filter
  wire btn_diff = btn_s2_r ^ btn_db_r;
  wire deb_done = btn_diff && (deb_cnt_r == DEB_C);
  wire press_end = deb_done & btn_db_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      btn_s1_r  <= 1'b1;                                          // start as held: a stuck button is seen
      btn_s2_r  <= 1'b1;                                          // a short blip is too brief to debounce
      btn_db_r  <= 1'b0;
      deb_cnt_r <= '0;
    end
    else
    begin
      btn_s1_r  <= reset_btn;
      btn_s2_r  <= btn_s1_r;
      deb_cnt_r <= btn_diff ? deb_cnt_r + 1'b1 : '0;
      if (deb_done)
        btn_db_r <= btn_s2_r;
    end
  end

  // press length; saturates just past the upper limit so long presses stay invalid
  wire press_in_window = (press_cnt_r >= MIN_C) && (press_cnt_r <= MAX_C);
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      press_cnt_r   <= '0;
      valid_reset_r <= 1'b0;
      pwr_press_r   <= 1'b1;
    end
    else
    begin
      if (deb_done & ~btn_db_r)
        press_cnt_r <= '0;
      else if (btn_db_r && press_cnt_r != SAT_C)
        press_cnt_r <= press_cnt_r + 1'b1;
      valid_reset_r <= press_end & press_in_window;
      if (!btn_s2_r)
        pwr_press_r <= 1'b0;
    end
  end

  // scan over all beams of the cascade; beam 0 carries the sync code
  assign total    = beams_total(beams_r, ctrl_r.units);
  assign last_idx = total - 1'b1;
  wire scan_on    = ctrl_r.scan_en && (total != '0);
  wire at_last    = idx_r == last_idx;
  wire sync_beam  = idx_r == '0;
  wire blocked    = ~beam_lit | (sync_beam & ~sync_code_ok);
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx_r         <= '0;
      acc_r         <= 1'b0;
      field_clear_r <= 1'b0;
    end
    else if (!scan_on)
    begin
      idx_r         <= '0;
      acc_r         <= 1'b0;
      field_clear_r <= 1'b0;
    end
    else
    begin
      idx_r <= at_last ? '0 : idx_r + 1'b1;
      acc_r <= at_last ? 1'b0 : (acc_r | blocked);
      if (at_last)
        field_clear_r <= ~(acc_r | blocked);
    end
  end

  // fault detection, fixed priority
  wire opt_fault  = scan_on & sync_code_ok & ~sync_beam;
  wire casc_fault = ctrl_r.scan_en & ((ctrl_r.units == '0) | (ctrl_r.units > curtain_pkg::UNITS_LIMIT)
                    | ((ctrl_r.units != 3'h1) & ~cascade_link_ok));
  wire fb_timeout = fb_pending_r && (fbt_r == FB_C);
  wire rst_fault  = pwr_press_r & (press_cnt_r == SAT_C);
  wire out_fault  = mismatch_r & (output_readback != outs_r);
  assign fault_now = internal_fault ? curtain_pkg::FLT_INTERNAL :
                     supply_fault   ? curtain_pkg::FLT_SUPPLY :
                     fb_timeout     ? curtain_pkg::FLT_CONTACTOR :
                     opt_fault      ? curtain_pkg::FLT_OPTICAL :
                     casc_fault     ? curtain_pkg::FLT_CASCADE :
                     rst_fault      ? curtain_pkg::FLT_RESTART :
                     out_fault      ? curtain_pkg::FLT_OUTPUT : curtain_pkg::FLT_NONE;

  // release needs a clear field, a closed feedback loop when monitored and, with interlock, a valid reset
  wire fb_ok      = ~monitor_cfg | fb_closed;
  wire reset_ok   = ~restart_cfg | valid_reset_r;
  wire release_ok = field_clear_r & master_cfg & fb_ok & reset_ok;
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      curtain_pkg::ST_OFF:
        if (fault_now != curtain_pkg::FLT_NONE)
          state_nxt = curtain_pkg::ST_LOCKOUT;
        else if (release_ok)
          state_nxt = curtain_pkg::ST_ON;
      curtain_pkg::ST_ON:
        if (fault_now != curtain_pkg::FLT_NONE)
          state_nxt = curtain_pkg::ST_LOCKOUT;
        else if (!field_clear_r || !master_cfg)
          state_nxt = curtain_pkg::ST_OFF;
      curtain_pkg::ST_LOCKOUT:
        state_nxt = curtain_pkg::ST_LOCKOUT;
    endcase
  end

  // power-up lands in off, so an interlocked receiver always waits for a reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= curtain_pkg::ST_OFF;
      outs_r  <= 2'h0;
      fault_r <= curtain_pkg::FLT_NONE;
    end
    else
    begin
      state_r <= state_nxt;
      outs_r  <= {2{state_nxt == curtain_pkg::ST_ON}};
      if (state_r != curtain_pkg::ST_LOCKOUT && state_nxt == curtain_pkg::ST_LOCKOUT)
        fault_r <= fault_now;
    end
  end

  // dynamic feedback check: after each output edge, except one into lockout, the loop must follow in time
  wire out_edge = (state_nxt == curtain_pkg::ST_ON) != outs_r[0];
  wire fb_follow = outs_r[0] ? ~fb_closed : fb_closed;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fb_pending_r <= 1'b0;
      fbt_r        <= '0;
      mismatch_r   <= 1'b0;
    end
    else
    begin
      mismatch_r <= output_readback != outs_r;
      if (out_edge && state_nxt != curtain_pkg::ST_LOCKOUT)
      begin
        fb_pending_r <= monitor_cfg;
        fbt_r        <= '0;
      end
      else if (fb_pending_r)
      begin
        if (fb_follow || fb_timeout)                              // stop the wait once the fault is taken
          fb_pending_r <= 1'b0;
        fbt_r <= fbt_r + 1'b1;
      end
    end
  end

  // sticky events, write one to clear; a new event wins over its clear
  assign ev.field_int = field_prev_r & ~field_clear_r;
  assign ev.out_on    = ~outs_r[0] & (state_nxt == curtain_pkg::ST_ON) & (state_r == curtain_pkg::ST_OFF);
  assign ev.out_off   = outs_r[0] & (state_nxt != curtain_pkg::ST_ON);
  assign ev.lockout   = (state_r != curtain_pkg::ST_LOCKOUT) & (state_nxt == curtain_pkg::ST_LOCKOUT);
  wire [3:0] w1c = (wr & hit_istat) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_stat_r   <= 4'h0;
      field_prev_r <= 1'b0;
    end
    else
    begin
      irq_stat_r   <= (irq_stat_r & ~w1c) | ev;
      field_prev_r <= field_clear_r;
    end
  end

  // status view and machine-side outputs; a slave unit never drives the outputs, lockout or fault code
  assign st.rsvd        = '0;
  assign st.fault       = fault_r;
  assign st.lockout     = state_r == curtain_pkg::ST_LOCKOUT;
  assign st.outputs_on  = outs_r[0];
  assign st.field_clear = field_clear_r;
  assign st.restart_cfg = restart_cfg;
  assign st.monitor_cfg = monitor_cfg;
  assign st.fb_closed   = fb_closed;
  assign st.fb_pending  = fb_pending_r;
  assign safety_switching_output = outs_r;
  assign lockout    = master_cfg & st.lockout;
  assign fault_code = master_cfg ? fault_r : curtain_pkg::FLT_NONE;
  assign irq        = |(irq_stat_r & irq_mask_r);

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_release;
    state_r == curtain_pkg::ST_OFF && release_ok && fault_now == curtain_pkg::FLT_NONE;
  endsequence
  sequence s_on_two;
    (outs_r == 2'h3) [*2];
  endsequence

  a_field_drop_off: assert property (outs_r[0] && !field_clear_r |=> outs_r == 2'h0)
    else $error("outputs stayed on after interruption");
  a_no_auto_on: assert property (restart_cfg && !outs_r[0] && !valid_reset_r |=> !outs_r[0])
    else $error("outputs released without reset");
  a_press_window: assert property (valid_reset_r |-> $past(press_cnt_r) >= MIN_C && $past(press_cnt_r) <= MAX_C)
    else $error("reset accepted outside press window");
  a_reset_turns_on: assert property (s_release ##1 field_clear_r |-> outs_r == 2'h3)
    else $error("outputs not on after valid release");
  a_auto_restart: assert property ((!restart_cfg ##0 s_release) |=> s_on_two or (##1 !field_clear_r))
    else $error("automatic restart failed");
  a_fb_before_on: assert property ($rose(outs_r[0]) && monitor_cfg |-> $past(fb_closed))
    else $error("switched on with open feedback");
  a_fb_bound: assert property (fb_pending_r |-> fbt_r <= FB_C)
    else $error("feedback wait exceeded limit");
  a_fb_timeout_lock: assert property (fb_timeout |=> state_r == curtain_pkg::ST_LOCKOUT ##1 outs_r == 2'h0)
    else $error("feedback timeout did not lock out");
  a_lock_holds: assert property (state_r == curtain_pkg::ST_LOCKOUT |=> state_r == curtain_pkg::ST_LOCKOUT && outs_r == 2'h0)
    else $error("lockout left without power cycle");
  a_cascade_limit: assert property (ctrl_r.scan_en && ctrl_r.units > curtain_pkg::UNITS_LIMIT |=> state_r == curtain_pkg::ST_LOCKOUT)
    else $error("oversized cascade accepted");
  a_scan_wrap: assert property (scan_on && at_last |=> idx_r == '0)
    else $error("scan did not restart at first beam");

endmodule // restart_interlock_and_contactor_check
`default_nettype wire

// ===== bench/contactor_model.sv
// downstream contactor pair with guided feedback contact and output readback
`timescale 1ns/1ps
`default_nettype none
module contactor_model #(
  parameter int DLY = 10
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // coil drive and commanded misbehaviour (1 welded, 2 open)
  input  wire logic [1:0] drive,
  input  wire logic [1:0] mode,
  // feedback toward the curtain
  output logic            fb_closed,
  output logic [1:0]      readback
);
  int cnt;

  // readback mirrors the coils at once
  assign readback = drive;

  // nc contact follows the coil after a mechanical delay
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fb_closed <= 1'b1;
      cnt       <= 0;
    end
    else if (mode != 2'h0)
      fb_closed <= (mode == 2'h1);
    else if (fb_closed == drive[0])
    begin
      cnt <= (cnt >= DLY) ? 0 : cnt + 1;
      if (cnt >= DLY)
        fb_closed <= !drive[0];
    end
    else
      cnt <= 0;
  end
endmodule // contactor_model
`default_nettype wire

// ===== bench/restart_interlock_and_contactor_check_bench.sv
// self-checking bench of the restart interlock and contactor check
`timescale 1ns/1ps
`default_nettype none
module restart_interlock_and_contactor_check_bench;
  localparam int MIN_C = 20;
  localparam int MAX_C = 200;
  logic                ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                restart_cfg, monitor_cfg, master_cfg, reset_btn, fb_closed, beam_lit;
  logic                sync_code_ok, cascade_link_ok, internal_fault, supply_fault, lockout, irq;
  logic [1:0]          output_readback, safety_switching_output, fb_mode;
  curtain_pkg::fault_t fault_code;
  curtain_pkg::fault_t exp_flt [7];
  int                  failures, total_checks, k, n;

  restart_interlock_and_contactor_check #(.PRESS_MIN_CYC(MIN_C), .PRESS_MAX_CYC(MAX_C), .FB_LIMIT_CYC(50),
    .DEBOUNCE_CYC(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .restart_cfg(restart_cfg), .monitor_cfg(monitor_cfg), .master_cfg(master_cfg), .reset_btn(reset_btn),
    .fb_closed(fb_closed), .beam_lit(beam_lit), .sync_code_ok(sync_code_ok), .cascade_link_ok(cascade_link_ok),
    .internal_fault(internal_fault), .supply_fault(supply_fault), .output_readback(output_readback),
    .safety_switching_output(safety_switching_output), .lockout(lockout), .fault_code(fault_code), .irq(irq));

  contactor_model #(.DLY(10)) contactors (.ref_clk(ref_clk), .rst_b(rst_b), .drive(safety_switching_output),
    .mode(fb_mode), .fb_closed(fb_closed), .readback(output_readback));

  // 100 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    c = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && c < 100)
    begin
      c++;
      @(posedge ref_clk);
    end
    if (c >= 100)
      chk(32'h0, 32'h1, "apb hang");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic settle(input int cyc);
    repeat (cyc) @(posedge ref_clk);
    #1;
  endtask

  // power cycle with static wiring
  task automatic power_up(input logic rs, input logic mon, input logic mst, input logic [1:0] fm);
    @(posedge ref_clk);
    rst_b <= 1'b0; restart_cfg <= rs; monitor_cfg <= mon; master_cfg <= mst; fb_mode <= fm;
    internal_fault <= 1'b0; supply_fault <= 1'b0; cascade_link_ok <= 1'b1; beam_lit <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask

  task automatic setup(input logic [2:0] units, input logic [31:0] beams);
    apb(1'b1, curtain_pkg::ADDR_BEAMS, beams);
    apb(1'b1, curtain_pkg::ADDR_CTRL, {28'h0, units, 1'b1});
  endtask

  task automatic press(input int len);
    @(posedge ref_clk);
    reset_btn <= 1'b1;
    repeat (len) @(posedge ref_clk);
    reset_btn <= 1'b0;
    settle(30);
  endtask

  task automatic wait_out(input logic [1:0] exp);
    for (n = 0; n < 100 && safety_switching_output !== exp; n++)
      settle(1);
    chk({30'h0, safety_switching_output}, {30'h0, exp}, "outputs");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #300us;
    failures++;
    tally_and_finish;
  end

  // test sequence
  initial
  begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; reset_btn = 1'b0; rst_b = 1'b0;
    restart_cfg = 1'b1; monitor_cfg = 1'b1; master_cfg = 1'b1; beam_lit = 1'b1; sync_code_ok = 1'b1;
    cascade_link_ok = 1'b1; internal_fault = 1'b0; supply_fault = 1'b0; fb_mode = 2'h0;
    exp_flt = '{curtain_pkg::FLT_INTERNAL, curtain_pkg::FLT_SUPPLY, curtain_pkg::FLT_OPTICAL,
                curtain_pkg::FLT_CASCADE, curtain_pkg::FLT_CASCADE, curtain_pkg::FLT_NONE,
                curtain_pkg::FLT_RESTART};
    power_up(1'b1, 1'b1, 1'b1, 2'h0);
    apb(1'b0, curtain_pkg::ADDR_CTRL, 32'h0);
    chk(rd, curtain_pkg::CTRL_RST, "ctrl reset");
    apb(1'b0, curtain_pkg::ADDR_BEAMS, 32'h0);
    chk(rd, curtain_pkg::BEAMS_RST, "beams reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    setup(3'h1, 32'h0000_0001);
    settle(30);
    chk({30'h0, safety_switching_output}, 32'h0, "no auto start");
    apb(1'b0, curtain_pkg::ADDR_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h1, "field clear, off");
    press(8);
    wait_out(2'b00);
    press(260);
    wait_out(2'b00);
    apb(1'b1, curtain_pkg::ADDR_IRQ_MASK, 32'h2);
    press(50);
    wait_out(2'b11);
    settle(2);
    chk({31'h0, irq}, 32'h1, "irq on");
    apb(1'b1, curtain_pkg::ADDR_IRQ_STAT, 32'hf);
    settle(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    settle(80);
    chk({31'h0, lockout}, 32'h0, "feedback in time");
    beam_lit <= 1'b0;
    wait_out(2'b00);
    beam_lit <= 1'b1;
    settle(60);
    chk({30'h0, safety_switching_output}, 32'h0, "held off");
    fb_mode <= 2'h1;
    press(50);
    wait_out(2'b11);
    settle(120);
    chk({28'h0, lockout, fault_code}, {28'h1, curtain_pkg::FLT_CONTACTOR}, "weld lockout");
    chk({30'h0, safety_switching_output}, 32'h0, "weld off");
    fb_mode <= 2'h0;
    press(50);
    chk({30'h0, lockout, safety_switching_output[0]}, 32'h2, "reset ignored");
    power_up(1'b1, 1'b1, 1'b1, 2'h2);
    setup(3'h1, 32'h0000_0001);
    press(50);
    wait_out(2'b00);
    power_up(1'b0, 1'b0, 1'b1, 2'h1);
    setup(3'h1, 32'h0000_0001);
    wait_out(2'b11);
    settle(120);
    chk({31'h0, lockout}, 32'h0, "monitor off");
    beam_lit <= 1'b0;
    wait_out(2'b00);
    beam_lit <= 1'b1;
    wait_out(2'b11);
    power_up(1'b0, 1'b0, 1'b0, 2'h0);
    setup(3'h1, 32'h0000_0001);
    settle(60);
    chk({29'h0, lockout, safety_switching_output}, 32'h0, "slave silent");
    // fault causes, one per power cycle; the three-unit cascade raises none
    for (k = 0; k < 7; k++)
    begin
      reset_btn <= (k == 6);
      power_up(1'b1, 1'b1, 1'b1, 2'h0);
      cascade_link_ok <= (k != 4);
      setup((k == 3) ? 3'h4 : (k == 4) ? 3'h2 : (k == 5) ? 3'h3 : 3'h1, (k == 2) ? 32'h2 : 32'h1);
      internal_fault <= (k == 0);
      supply_fault <= (k == 1);
      for (n = 0; n < 300 && lockout !== 1'b1; n++)
        settle(1);
      chk({29'h0, fault_code}, {29'h0, exp_flt[k]}, "fault code");
    end
    tally_and_finish;
  end
endmodule // restart_interlock_and_contactor_check_bench
`default_nettype wire
